// ### hdl/nac_pkg.sv
package nac_pkg;

	// Register byte addresses on the plain register port
	localparam int            ADDR_W          = 9;
	localparam logic [8:0]    OFS_ADDR_LOW    = 9'h180;
	localparam logic [8:0]    OFS_ADDR_HIGH   = 9'h184;
	localparam logic [8:0]    OFS_DATA_LOW    = 9'h188;
	localparam logic [8:0]    OFS_CTRL        = 9'h18C;
	localparam logic [8:0]    OFS_DATA_HIGH   = 9'h190;
	localparam logic [8:0]    OFS_UNLOCK      = 9'h194;
	localparam logic [8:0]    OFS_IRQ_STATUS  = 9'h198;
	localparam logic [8:0]    OFS_IRQ_MASK    = 9'h19C;

	// Control register field positions
	localparam int            CTL_RD_GO       = 0;
	localparam int            CTL_WR_GO       = 1;
	localparam int            CTL_ALLOW       = 2;
	localparam int            CTL_ABORT       = 3;
	localparam int            CTL_SPACE       = 7;

	// Interrupt status and mask field positions
	localparam int            IRQ_W           = 2;
	localparam int            IRQ_WR_DONE     = 0;
	localparam int            IRQ_RD_DONE     = 1;

	// Unlock key values, in the order they must arrive
	localparam logic [7:0]    UNLOCK_KEY1     = 8'h55;
	localparam logic [7:0]    UNLOCK_KEY2     = 8'hAA;

	// Read latency in clock cycles per memory space
	localparam logic [1:0]    DATA_READ_CYC   = 2'h1;
	localparam logic [1:0]    FLASH_READ_CYC  = 2'h2;

	// Clock and default write duration
	localparam int            CLOCK_PERIOD_PS = 5000;
	localparam int            WRITE_TIME_US   = 4000;

	// Reset values
	localparam logic [7:0]    RST_BYTE        = 8'h00;
	localparam logic [1:0]    RST_IRQ         = 2'h0;

	// Unlock tracker states
	typedef enum logic [1:0] {
		NAC_UL_IDLE,
		NAC_UL_GOT_KEY1,
		NAC_UL_ARMED
	} nac_unlock_t;

endpackage

// ### hdl/nac_write_timer.sv
`timescale 1ns/1ps
`default_nettype none

module nac_write_timer #(
	parameter int CYCLES = 800000
) (
	input  wire logic i_clock,
	input  wire logic i_resetn,
	input  wire logic i_start,
	input  wire logic i_abort,
	output logic      o_busy,
	output logic      o_done
);

	localparam int CNT_W = $clog2(CYCLES + 1);
	localparam logic [CNT_W-1:0] LOAD    = CNT_W'(CYCLES);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

	if (CYCLES < 1) begin : g_chk
		$error("nac_write_timer: CYCLES must be at least 1");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             done;
	} nac_tmr_t;

	nac_tmr_t st_ff;
	nac_tmr_t nxt_st;

	// Count down the write; an abort drops the count with no done pulse
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (i_abort) begin
			nxt_st.cnt = CNT_ZERO;
		end else if (i_start) begin
			nxt_st.cnt = LOAD;
		end else if (st_ff.cnt != CNT_ZERO) begin
			nxt_st.cnt = st_ff.cnt - CNT_ONE;
			nxt_st.done = (st_ff.cnt == CNT_ONE);
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_busy = (st_ff.cnt != CNT_ZERO);
	assign o_done = st_ff.done;

endmodule

`default_nettype wire

// ### hdl/nac_access_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module nac_access_ctrl #(
	parameter int ADDR_HI_W     = 5,
	parameter int DATA_HI_W     = 6,
	parameter int WRITE_TIME_US = nac_pkg::WRITE_TIME_US
) (
	input  wire logic        i_clock,
	input  wire logic        i_resetn,
	input  wire logic        i_ext_reset_pin_rst,
	input  wire logic        i_dog_timer_rst,
	input  wire logic [8:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	output logic      [12:0] o_mem_addr,
	output logic      [13:0] o_mem_wdata,
	output logic             o_mem_space,
	output logic             o_mem_rd,
	output logic             o_mem_wr,
	input  wire logic [13:0] i_mem_rdata,
	output logic             o_irq
);

	localparam longint WRITE_PS     = longint'(WRITE_TIME_US) * 64'd1000000;
	localparam int     WRITE_CYCLES = int'(WRITE_PS / longint'(nac_pkg::CLOCK_PERIOD_PS));

	// Ports are sized for the full 13-bit address and 14-bit word
	if (ADDR_HI_W != 5 || DATA_HI_W != 6 || WRITE_CYCLES < 1) begin : g_chk
		$error("nac_access_ctrl: unsupported width or write time");
	end

	typedef struct packed {
		logic [7:0]                  addr_lo;
		logic [ADDR_HI_W-1:0]        addr_hi;
		logic [7:0]                  data_lo;
		logic [DATA_HI_W-1:0]        data_hi;
		logic                        space;
		logic                        abort;
		logic                        allow;
		logic                        wr_go;
		logic                        rd_go;
		nac_pkg::nac_unlock_t        unlock;
		logic [1:0]                  rd_cnt;
		logic                        mem_rd;
		logic                        mem_wr;
		logic [12:0]                 mem_addr;
		logic [nac_pkg::IRQ_W-1:0]   irq_stat;
		logic [nac_pkg::IRQ_W-1:0]   irq_mask;
		logic                        irq;
		logic [7:0]                  rdata;
	} nac_state_t;

	nac_state_t st_ff;
	nac_state_t nxt_st;
	logic       warm_rst;
	logic       start_write;
	logic       timer_done;
	logic       busy;
	logic       ctrl_wr;

	assign warm_rst = i_ext_reset_pin_rst | i_dog_timer_rst;
	assign busy     = st_ff.mem_wr | (st_ff.rd_cnt != 2'h0);
	assign ctrl_wr  = i_wr && (i_addr == nac_pkg::OFS_CTRL);

	// Write starts only when armed by the key pair and allowed before this access
	assign start_write = ctrl_wr && i_wdata[nac_pkg::CTL_WR_GO] && !warm_rst
		&& (st_ff.unlock == nac_pkg::NAC_UL_ARMED)
		&& st_ff.allow && !busy;

	// Internal timer fixes write length, not software
	nac_write_timer #(
		.CYCLES (WRITE_CYCLES)
	) u_timer (
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.i_start  (start_write),
		.i_abort  (warm_rst),
		.o_busy   (),
		.o_done   (timer_done)
	);

	// Next state of the whole block
	always_comb begin
		logic [nac_pkg::IRQ_W-1:0] events;
		events = '0;
		nxt_st = st_ff;
		nxt_st.rdata = nac_pkg::RST_BYTE;

		// Unlock tracker: any access that is not the next step drops it
		if (i_wr || i_rd) begin
			nxt_st.unlock = nac_pkg::NAC_UL_IDLE;
		end
		if (i_wr && i_addr == nac_pkg::OFS_UNLOCK) begin
			if (i_wdata == nac_pkg::UNLOCK_KEY1) begin
				nxt_st.unlock = nac_pkg::NAC_UL_GOT_KEY1;
			end else if (i_wdata == nac_pkg::UNLOCK_KEY2
				&& st_ff.unlock == nac_pkg::NAC_UL_GOT_KEY1) begin
				nxt_st.unlock = nac_pkg::NAC_UL_ARMED;
			end
		end

		// Address and data holding registers, frozen while an access runs
		if (i_wr && !busy) begin
			case (i_addr)
				nac_pkg::OFS_ADDR_LOW: begin
					nxt_st.addr_lo = i_wdata;
				end
				nac_pkg::OFS_ADDR_HIGH: begin
					nxt_st.addr_hi = i_wdata[ADDR_HI_W-1:0];
				end
				nac_pkg::OFS_DATA_LOW: begin
					nxt_st.data_lo = i_wdata;
				end
				nac_pkg::OFS_DATA_HIGH: begin
					nxt_st.data_hi = i_wdata[DATA_HI_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Control register: start bits are set-only, bits 6 to 4 dropped
		if (ctrl_wr) begin
			nxt_st.allow = i_wdata[nac_pkg::CTL_ALLOW];
			nxt_st.abort = i_wdata[nac_pkg::CTL_ABORT];
			if (!busy) begin
				nxt_st.space = i_wdata[nac_pkg::CTL_SPACE];
			end
			if (start_write) begin
				nxt_st.wr_go  = 1'b1;
				nxt_st.mem_wr = 1'b1;
				nxt_st.mem_addr = nxt_st.space ? {nxt_st.addr_hi, nxt_st.addr_lo}
					: {5'h00, nxt_st.addr_lo};
			end else if (i_wdata[nac_pkg::CTL_RD_GO] && !busy) begin
				nxt_st.rd_go  = 1'b1;
				nxt_st.rd_cnt = nxt_st.space ? nac_pkg::FLASH_READ_CYC
					: nac_pkg::DATA_READ_CYC;
				nxt_st.mem_addr = nxt_st.space ? {nxt_st.addr_hi, nxt_st.addr_lo}
					: {5'h00, nxt_st.addr_lo};
			end
		end

		// Read completes on its last cycle; bytes held until next read or write
		if (st_ff.rd_cnt != 2'h0) begin
			nxt_st.rd_cnt = st_ff.rd_cnt - 2'h1;
			if (st_ff.rd_cnt == 2'h1) begin
				nxt_st.data_lo = i_mem_rdata[7:0];
				if (st_ff.space) begin
					nxt_st.data_hi = i_mem_rdata[13:8];
				end
				nxt_st.rd_go = 1'b0;
				events[nac_pkg::IRQ_RD_DONE] = 1'b1;
			end
		end

		// Write end: start bit cleared and done flag raised together
		if (timer_done) begin
			nxt_st.wr_go  = 1'b0;
			nxt_st.mem_wr = 1'b0;
			events[nac_pkg::IRQ_WR_DONE] = 1'b1;
		end

		// Warm reset: a cut write raises abort; address, data, space kept
		if (warm_rst) begin
			if (st_ff.mem_wr) begin
				nxt_st.abort = 1'b1;
			end
			nxt_st.wr_go  = 1'b0;
			nxt_st.rd_go  = 1'b0;
			nxt_st.mem_wr = 1'b0;
			nxt_st.rd_cnt = 2'h0;
			nxt_st.allow  = 1'b0;
			nxt_st.unlock = nac_pkg::NAC_UL_IDLE;
		end

		// Interrupt status is write-one-to-clear; a new event beats the clear
		if (i_wr && i_addr == nac_pkg::OFS_IRQ_STATUS) begin
			nxt_st.irq_stat = st_ff.irq_stat & ~i_wdata[nac_pkg::IRQ_W-1:0];
		end
		if (i_wr && i_addr == nac_pkg::OFS_IRQ_MASK) begin
			nxt_st.irq_mask = i_wdata[nac_pkg::IRQ_W-1:0];
		end
		nxt_st.irq_stat = nxt_st.irq_stat | events;
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

		// Read data stands only in the cycle after the strobe
		if (i_rd) begin
			case (i_addr)
				nac_pkg::OFS_ADDR_LOW:   nxt_st.rdata = st_ff.addr_lo;
				nac_pkg::OFS_ADDR_HIGH:  nxt_st.rdata = {3'h0, st_ff.addr_hi};
				nac_pkg::OFS_DATA_LOW:   nxt_st.rdata = st_ff.data_lo;
				nac_pkg::OFS_DATA_HIGH:  nxt_st.rdata = {2'h0, st_ff.data_hi};
				nac_pkg::OFS_CTRL:       nxt_st.rdata = {st_ff.space, 3'h0,
					st_ff.abort, st_ff.allow, st_ff.wr_go, st_ff.rd_go};
				nac_pkg::OFS_UNLOCK:     nxt_st.rdata = nac_pkg::RST_BYTE;
				nac_pkg::OFS_IRQ_STATUS: nxt_st.rdata = {6'h00, st_ff.irq_stat};
				nac_pkg::OFS_IRQ_MASK:   nxt_st.rdata = {6'h00, st_ff.irq_mask};
				default:                 nxt_st.rdata = nac_pkg::RST_BYTE;
			endcase
		end

		nxt_st.mem_rd = (nxt_st.rd_cnt != 2'h0);
	end

	// Power-up reset clears everything, abort flag included
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			st_ff <= '{
				addr_lo:  nac_pkg::RST_BYTE,
				addr_hi:  '0,
				data_lo:  nac_pkg::RST_BYTE,
				data_hi:  '0,
				space:    1'b0,
				abort:    1'b0,
				allow:    1'b0,
				wr_go:    1'b0,
				rd_go:    1'b0,
				unlock:   nac_pkg::NAC_UL_IDLE,
				rd_cnt:   2'h0,
				mem_rd:   1'b0,
				mem_wr:   1'b0,
				mem_addr: 13'h0000,
				irq_stat: nac_pkg::RST_IRQ,
				irq_mask: nac_pkg::RST_IRQ,
				irq:      1'b0,
				rdata:    nac_pkg::RST_BYTE
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_rdata     = st_ff.rdata;
	assign o_mem_addr  = st_ff.mem_addr;
	assign o_mem_wdata = {st_ff.data_hi, st_ff.data_lo};
	assign o_mem_space = st_ff.space;
	assign o_mem_rd    = st_ff.mem_rd;
	assign o_mem_wr    = st_ff.mem_wr;
	assign o_irq       = st_ff.irq;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	a_unlock_reads_zero: assert property (
		i_rd && i_addr == nac_pkg::OFS_UNLOCK |=> o_rdata == 8'h00
	) else $error("unlock port read not zero");

	a_ctrl_gaps_zero: assert property (
		i_rd && i_addr == nac_pkg::OFS_CTRL |=> o_rdata[6:4] == 3'h0
	) else $error("control bits 6 to 4 not zero");

	a_start_needs_arm: assert property (
		$rose(o_mem_wr) |-> $past(st_ff.allow) && $past(st_ff.unlock) == nac_pkg::NAC_UL_ARMED
			&& $past(ctrl_wr)
	) else $error("write began without allow and unlock");

	a_write_holds: assert property (
		o_mem_wr && !timer_done && !warm_rst |=> o_mem_wr && st_ff.wr_go
	) else $error("write dropped before its end");

	a_done_sets_flag: assert property (
		timer_done && !warm_rst |=> st_ff.irq_stat[nac_pkg::IRQ_WR_DONE] && !st_ff.wr_go
			&& !o_mem_wr
	) else $error("write end did not set done flag");

	a_abort_keeps: assert property (
		warm_rst && o_mem_wr |=> st_ff.abort && !o_mem_wr && $stable(st_ff.addr_lo)
			&& $stable(st_ff.data_lo) && $stable(st_ff.space)
	) else $error("abort flag or kept registers wrong");

	a_data_read_time: assert property (
		ctrl_wr && i_wdata[0] && !i_wdata[7] && !busy && !start_write && !warm_rst
		|=> o_mem_rd ##1 !o_mem_rd && st_ff.data_lo == $past(i_mem_rdata[7:0])
	) else $error("data read not ready next cycle");

	a_flash_read_time: assert property (
		ctrl_wr && i_wdata[0] && i_wdata[7] && !busy && !start_write && !warm_rst
		|=> o_mem_rd [*2] ##1 !o_mem_rd && !st_ff.rd_go
	) else $error("flash read not two cycles");

	a_allow_sticky: assert property (
		st_ff.allow && !ctrl_wr && !warm_rst |=> st_ff.allow
	) else $error("write allow cleared by hardware");

	a_tracker_drops: assert property (
		st_ff.unlock == nac_pkg::NAC_UL_GOT_KEY1 && i_rd |=> st_ff.unlock == nac_pkg::NAC_UL_IDLE
	) else $error("unlock tracker survived other access");

	a_data_space_addr: assert property (
		$rose(o_mem_rd) && !o_mem_space |-> o_mem_addr[12:8] == 5'h00
	) else $error("data space address above 255");

endmodule

`default_nettype wire

// ### verif/nac_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// Memory arrays on the far side of the access block
module nac_mem_model (
	input  wire logic        i_clock,
	input  wire logic [12:0] i_addr,
	input  wire logic [13:0] i_wdata,
	input  wire logic        i_space,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	output logic      [13:0] o_rdata
);
	// Fixed arrays rather than a sparse map, so any free simulator takes them
	logic [13:0] mem  [16384];
	bit          used [16384];
	logic        wr_ff;
	logic [13:0] last_ff;

	// Untouched cells hold an address-derived pattern
	function automatic logic [13:0] word(input logic s, input logic [12:0] a);
		return used[{s, a}] ? mem[{s, a}] : ({a, 1'b1} ^ {s, 13'h0A5C});
	endfunction

	// Outside a read the word flips each cycle, so stale data never matches
	always @* begin
		o_rdata = i_rd ? word(i_space, i_addr) : ~last_ff;
	end

	// Cell taken at write start; the block times the write itself
	always @(posedge i_clock) begin
		wr_ff <= i_wr;
		last_ff <= o_rdata;
		if (i_wr === 1'b1 && wr_ff === 1'b0) begin
			mem[{i_space, i_addr}] <= i_wdata;
			used[{i_space, i_addr}] <= 1'b1;
		end
	end
endmodule

`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        i_clock  = 1'b0;
	logic        i_resetn = 1'b0;
	logic        ext_rst  = 1'b0;
	logic        dog_rst  = 1'b0;
	logic [8:0]  addr     = 9'h000;
	logic [7:0]  wdata    = 8'h00;
	logic        wr       = 1'b0;
	logic        rd       = 1'b0;
	logic        rd_d     = 1'b0;
	logic [7:0]  rdata;
	logic [12:0] maddr;
	logic [13:0] mwdata;
	logic [13:0] mrdata;
	logic        mspace;
	logic        mrd;
	logic        mwr;
	logic        irq;
	logic [7:0]  expq [$];
	logic [12:0] fa;
	logic [7:0]  da;
	logic [7:0]  dd;
	logic [13:0] w;
	int          miscompares = 0;
	int          n_tests     = 0;
	int          cycles      = 0;
	int          wr_len      = 0;
	int          last_len    = 0;

	// Short write time keeps the run brief; cycles follow from the clock period
	localparam int WR_US  = 1;
	localparam int WR_CYC = WR_US * 1000000 / nac_pkg::CLOCK_PERIOD_PS;

	// 200 MHz clock
	always #2.5 i_clock = ~i_clock;

	nac_access_ctrl #(.WRITE_TIME_US(WR_US)) i_dut (
		.i_clock(i_clock), .i_resetn(i_resetn), .i_ext_reset_pin_rst(ext_rst),
		.i_dog_timer_rst(dog_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .o_mem_addr(maddr), .o_mem_wdata(mwdata),
		.o_mem_space(mspace), .o_mem_rd(mrd), .o_mem_wr(mwr),
		.i_mem_rdata(mrdata), .o_irq(irq)
	);

	nac_mem_model i_mem (
		.i_clock(i_clock), .i_addr(maddr), .i_wdata(mwdata), .i_space(mspace),
		.i_rd(mrd), .i_wr(mwr), .o_rdata(mrdata)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("comparisons %0d, miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One bus cycle; every signal set once per edge
	task automatic bus(input logic w_, input logic r_, input logic [8:0] a, input logic [7:0] d);
		wr <= w_;
		rd <= r_;
		addr <= a;
		wdata <= d;
		@(posedge i_clock);
	endtask

	task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask

	task automatic rd_reg(input logic [8:0] a, input logic [7:0] e);
		expq.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask

	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 9'h000, 8'h00);
	endtask

	// Level outputs looked at mid-cycle; strobes dropped first so none repeats
	task automatic lvl(input int sel, input logic e);
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge i_clock);
		check(sel ? irq : mwr, e);
		@(posedge i_clock);
	endtask

	// Keys and start back to back, nothing else on the bus in between
	task automatic unlock_go(input logic [7:0] c);
		wr_reg(nac_pkg::OFS_UNLOCK, nac_pkg::UNLOCK_KEY1);
		wr_reg(nac_pkg::OFS_UNLOCK, nac_pkg::UNLOCK_KEY2);
		wr_reg(nac_pkg::OFS_CTRL, c);
	endtask

	task automatic wait_done();
		for (int k = 0; k < 400 && mwr !== 1'b0; k++)
			idle(1);
		idle(1);
		lvl(0, 1'b0);
	endtask

	// Read data stand one cycle after the strobe; oldest note is compared
	always @(posedge i_clock) begin
		cycles++;
		if (rd_d)
			check(rdata, expq.pop_front());
		rd_d <= rd;
		// Length of each write pulse, kept once it ends
		if (mwr === 1'b1) begin
			wr_len++;
		end else if (wr_len != 0) begin
			last_len = wr_len;
			wr_len = 0;
		end
		if (cycles == 5000) begin
			miscompares++;
			results();
		end
	end

	initial begin
		void'($urandom(32'h2f7db532));
		da = 8'($urandom);
		dd = 8'($urandom);
		fa = 13'($urandom);
		repeat (5) @(posedge i_clock);
		i_resetn <= 1'b1;
		idle(1);
		// Reset values, unlock port and unmapped space
		rd_reg(nac_pkg::OFS_CTRL, 8'h00);
		rd_reg(nac_pkg::OFS_IRQ_STATUS, 8'h00);
		wr_reg(nac_pkg::OFS_UNLOCK, 8'hFF);
		rd_reg(nac_pkg::OFS_UNLOCK, 8'h00);
		rd_reg(9'h1A0, 8'h00);
		wr_reg(nac_pkg::OFS_CTRL, 8'h70);
		rd_reg(nac_pkg::OFS_CTRL, 8'h00);
		// Data-space read at a random byte address
		wr_reg(nac_pkg::OFS_ADDR_LOW, da);
		wr_reg(nac_pkg::OFS_CTRL, 8'h01);
		idle(1);
		w = i_mem.word(1'b0, {5'h00, da});
		rd_reg(nac_pkg::OFS_DATA_LOW, w[7:0]);
		rd_reg(nac_pkg::OFS_CTRL, 8'h00);
		// Flash read fills both data registers
		wr_reg(nac_pkg::OFS_ADDR_HIGH, {3'h0, fa[12:8]});
		wr_reg(nac_pkg::OFS_ADDR_LOW, fa[7:0]);
		wr_reg(nac_pkg::OFS_CTRL, 8'h81);
		idle(2);
		w = i_mem.word(1'b1, fa);
		rd_reg(nac_pkg::OFS_DATA_LOW, w[7:0]);
		rd_reg(nac_pkg::OFS_DATA_HIGH, {2'h0, w[13:8]});
		rd_reg(nac_pkg::OFS_CTRL, 8'h80);
		// Refused starts: allow in same write, keys swapped, access between keys
		wr_reg(nac_pkg::OFS_CTRL, 8'h00);
		wr_reg(nac_pkg::OFS_ADDR_LOW, da);
		wr_reg(nac_pkg::OFS_DATA_LOW, dd);
		unlock_go(8'h06);
		lvl(0, 1'b0);
		rd_reg(nac_pkg::OFS_CTRL, 8'h04);
		wr_reg(nac_pkg::OFS_UNLOCK, nac_pkg::UNLOCK_KEY2);
		wr_reg(nac_pkg::OFS_UNLOCK, nac_pkg::UNLOCK_KEY1);
		wr_reg(nac_pkg::OFS_CTRL, 8'h06);
		rd_reg(nac_pkg::OFS_CTRL, 8'h04);
		wr_reg(nac_pkg::OFS_UNLOCK, nac_pkg::UNLOCK_KEY1);
		rd_reg(nac_pkg::OFS_DATA_LOW, dd);
		wr_reg(nac_pkg::OFS_UNLOCK, nac_pkg::UNLOCK_KEY2);
		wr_reg(nac_pkg::OFS_CTRL, 8'h06);
		rd_reg(nac_pkg::OFS_CTRL, 8'h04);
		// Proper start; zero writes and allow clear do not stop it
		wr_reg(nac_pkg::OFS_IRQ_MASK, 8'h01);
		unlock_go(8'h06);
		lvl(0, 1'b1);
		wr_reg(nac_pkg::OFS_CTRL, 8'h04);
		rd_reg(nac_pkg::OFS_CTRL, 8'h06);
		wr_reg(nac_pkg::OFS_CTRL, 8'h00);
		rd_reg(nac_pkg::OFS_CTRL, 8'h02);
		lvl(1, 1'b0);
		wait_done();
		check(8'(last_len), 8'(WR_CYC + 1));
		idle(5);
		rd_reg(nac_pkg::OFS_CTRL, 8'h00);
		rd_reg(nac_pkg::OFS_IRQ_STATUS, 8'h03);
		lvl(1, 1'b1);
		wr_reg(nac_pkg::OFS_IRQ_MASK, 8'h00);
		lvl(1, 1'b0);
		wr_reg(nac_pkg::OFS_IRQ_MASK, 8'h01);
		wr_reg(nac_pkg::OFS_IRQ_STATUS, 8'h03);
		rd_reg(nac_pkg::OFS_IRQ_STATUS, 8'h00);
		lvl(1, 1'b0);
		// Written byte comes back from the array
		wr_reg(nac_pkg::OFS_DATA_LOW, ~dd);
		wr_reg(nac_pkg::OFS_CTRL, 8'h01);
		idle(1);
		rd_reg(nac_pkg::OFS_DATA_LOW, dd);
		// Warm reset in mid-write, pin then watchdog, both spaces
		for (int s = 0; s < 2; s++) begin
			wr_reg(nac_pkg::OFS_CTRL, {s[0], 7'h04});
			unlock_go({s[0], 7'h06});
			idle(3);
			ext_rst <= (s == 0);
			dog_rst <= (s == 1);
			idle(1);
			ext_rst <= 1'b0;
			dog_rst <= 1'b0;
			idle(1);
			rd_reg(nac_pkg::OFS_CTRL, {s[0], 7'h08});
			rd_reg(nac_pkg::OFS_ADDR_LOW, da);
			rd_reg(nac_pkg::OFS_DATA_LOW, dd);
			lvl(0, 1'b0);
		end
		// Power-up reset in mid-run clears abort and space; allow is already clear from the warm reset
		i_resetn <= 1'b0;
		idle(2);
		i_resetn <= 1'b1;
		idle(1);
		rd_reg(nac_pkg::OFS_CTRL, 8'h00);
		idle(2);
		results();
	end
endmodule

`default_nettype wire
